//--- rsp_pkg.sv
// Package with constants and a parity function for the rotary sensor serial slave port
package rsp_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam int unsigned MSB_POS = 15;

  // ----------------------------------------------------------------------
  // Commands (parity bit dropped before compare)
  // ----------------------------------------------------------------------
  localparam logic [14:0] CMD_NOP = 15'h0000;
  localparam logic [14:0] CMD_CLEAR_FAULT = 15'h7380;
  localparam logic [14:0] CMD_SOFT_RESET = 15'h3C00;
  localparam logic [14:0] CMD_READ_ERR = 15'h7340;
  localparam int unsigned SOFT_RES_DATA_BIT = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RELEASE_MAX_NS = 50;
  localparam int unsigned RELEASE_CYCLES = RELEASE_MAX_NS / CLK_PERIOD_NS;

  // Even parity over a whole word: true when parity holds
  function automatic logic rsp_parity_ok(input logic [15:0] w);
    return ~(^w);
  endfunction

endpackage

//--- rsp_sync.sv
// Two flip-flop synchroniser for the serial port pins
`timescale 1ns/10ps
module rsp_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // rsp_sync

//--- rsp_slave.sv
// Serial slave port of the rotary sensor: frame shifter, command pipe, fault flag
`timescale 1ns/10ps
module rsp_slave (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sck,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  input  wire logic        wire_mode_strap,
  input  wire logic [15:0] angle_word,
  output logic             miso,
  output logic             miso_oe_n,
  output logic             transfer_fault_flag,
  output logic             four_wire,
  output logic             frame_done,
  output logic [15:0]      cmd_word
);

  // --------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------
  logic [2:0] pins_s;

  rsp_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({sck, ss_n, mosi}),
    .dout    (pins_s)
  );

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSP_IDLE  = 2'b01,
    RSP_FRAME = 2'b10
  } rsp_state_e;

  typedef struct packed {
    rsp_state_e  state;
    logic        sck_d;
    logic        ss_d;
    logic [4:0]  bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [15:0] answer;
    logic        miso;
    logic        fault;
    logic        four_wire;
    logic        strap_taken;
    logic        frame_done;
    logic [15:0] cmd_word;
  } rsp_regs_s;

  rsp_regs_s r;
  rsp_regs_s next_r;

  logic sck_s;
  logic ss_s;
  logic mosi_s;
  assign sck_s  = pins_s[2];
  assign ss_s   = pins_s[1];
  assign mosi_s = pins_s[0];

  logic       sck_fall;
  logic       sck_rise;
  logic       ss_fall;
  logic       ss_rise;
  logic [15:0] word_in;
  logic [14:0] cmd_body;
  logic       bad_frame;

  always_comb begin
    next_r     = r;
    sck_fall   = r.sck_d & ~sck_s;
    sck_rise   = ~r.sck_d & sck_s;
    ss_fall    = r.ss_d & ~ss_s;
    ss_rise    = ~r.ss_d & ss_s;
    word_in    = r.shift_in;
    cmd_body   = word_in[15:1];
    bad_frame  = 1'b0;
    next_r.sck_d      = sck_s;
    next_r.ss_d       = ss_s;
    next_r.frame_done = 1'b0;

    // Strap caught once after reset release, again only after reset or a soft-reset command
    if (!r.strap_taken) begin
      next_r.four_wire   = wire_mode_strap;
      next_r.strap_taken = 1'b1;
    end

    unique case (r.state)
      RSP_IDLE: begin
        // Clock edges with select high are simply not looked at
        if (ss_fall) begin
          next_r.state     = RSP_FRAME;
          next_r.bit_cnt   = rsp_pkg::BIT_CNT_ZERO;
          next_r.shift_in  = rsp_pkg::WORD_ZERO;
          next_r.shift_out = r.answer;
          next_r.miso      = r.answer[rsp_pkg::MSB_POS];
        end
      end
      RSP_FRAME: begin
        if (sck_fall) begin
          next_r.shift_in = {r.shift_in[14:0], mosi_s};
          if (r.bit_cnt != 5'h1F) begin
            next_r.bit_cnt = r.bit_cnt + 5'h01;
          end
        end
        if (sck_rise && r.bit_cnt != rsp_pkg::BIT_CNT_ZERO) begin
          next_r.shift_out = {r.shift_out[14:0], 1'b0};
          next_r.miso      = r.shift_out[14];
        end
        if (ss_rise) begin
          next_r.state     = RSP_IDLE;
          next_r.miso      = 1'b0;
          next_r.frame_done = 1'b1;
          next_r.cmd_word  = word_in;
          // Fault sources: clock count, parity, unknown command with bit 15 set
          bad_frame = (r.bit_cnt != rsp_pkg::BIT_CNT_FULL)
                    || !rsp_pkg::rsp_parity_ok(word_in);
          if (!bad_frame && cmd_body != rsp_pkg::CMD_NOP &&
              cmd_body != rsp_pkg::CMD_CLEAR_FAULT &&
              cmd_body != rsp_pkg::CMD_SOFT_RESET &&
              cmd_body != rsp_pkg::CMD_READ_ERR && word_in[15]) begin
            bad_frame = 1'b1;
          end
          // Decoded answer is held for the next frame
          next_r.answer = {1'b0, angle_word[14:0]};
          if (bad_frame) begin
            next_r.fault = 1'b1;
          end else if (cmd_body == rsp_pkg::CMD_CLEAR_FAULT && r.four_wire) begin
            next_r.fault  = 1'b0;
            next_r.answer = rsp_pkg::WORD_ZERO;
          end else if (cmd_body == rsp_pkg::CMD_NOP) begin
            next_r.answer = rsp_pkg::WORD_ZERO;
          end else if (cmd_body == rsp_pkg::CMD_SOFT_RESET) begin
            next_r.strap_taken = 1'b0;
          end
          // Fault shows in the top bit of each reply word
          next_r.answer[rsp_pkg::MSB_POS] = next_r.fault;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r.state       <= RSP_IDLE;
      r.sck_d       <= 1'b0;
      r.ss_d        <= 1'b1;
      r.bit_cnt     <= rsp_pkg::BIT_CNT_ZERO;
      r.shift_in    <= rsp_pkg::WORD_ZERO;
      r.shift_out   <= rsp_pkg::WORD_ZERO;
      r.answer      <= rsp_pkg::WORD_ZERO;
      r.miso        <= 1'b0;
      r.fault       <= 1'b0;
      r.four_wire   <= 1'b0;
      r.strap_taken <= 1'b0;
      r.frame_done  <= 1'b0;
      r.cmd_word    <= rsp_pkg::WORD_ZERO;
    end else begin
      r <= next_r;
    end
  end

  assign miso                = r.miso;
  // Enable taken straight from the select synchroniser: one more register would
  // release 60 ns after select rises, past the 50 ns limit. Drive starts a clock
  // before the top bit is loaded, long before the master's first sampling edge.
  assign miso_oe_n           = ss_s;
  assign transfer_fault_flag = r.fault;
  assign four_wire           = r.four_wire;
  assign frame_done          = r.frame_done;
  assign cmd_word            = r.cmd_word;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence ss_rise_seen;
    r.state == RSP_FRAME && ss_rise;
  endsequence

  release_after_ss_a: assert property (@(posedge clk_sys) disable iff (reset)
    ss_rise_seen |=> miso_oe_n)
    else $error("output not released after select rise");

  drive_in_frame_a: assert property (@(posedge clk_sys) disable iff (reset)
    (r.state == RSP_IDLE && ss_fall) |=> !miso_oe_n)
    else $error("output not driven at frame start");

  counter_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    (r.state == RSP_IDLE && ss_fall) |=>
      r.bit_cnt == rsp_pkg::BIT_CNT_ZERO && r.shift_in == rsp_pkg::WORD_ZERO)
    else $error("counter not cleared at select fall");

  idle_ignore_a: assert property (@(posedge clk_sys) disable iff (reset)
    (r.state == RSP_IDLE && !ss_fall) |=> $stable(r.bit_cnt))
    else $error("counter moved while idle");

  sample_fall_a: assert property (@(posedge clk_sys) disable iff (reset)
    (r.state == RSP_FRAME && sck_fall && r.bit_cnt < 5'h1F) |=>
      r.bit_cnt == $past(r.bit_cnt) + 5'h01)
    else $error("bit not counted on falling edge");

  msb_first_a: assert property (@(posedge clk_sys) disable iff (reset)
    (r.state == RSP_IDLE && ss_fall) |=> miso == $past(transfer_fault_flag))
    else $error("first bit is not the top bit");

  fault_on_count_a: assert property (@(posedge clk_sys) disable iff (reset)
    (ss_rise_seen and r.bit_cnt != rsp_pkg::BIT_CNT_FULL) |=> transfer_fault_flag)
    else $error("fault not set on wrong clock count");

  fault_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
    (transfer_fault_flag && !ss_rise) |=> transfer_fault_flag)
    else $error("fault cleared without command");

  strap_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (r.strap_taken && !ss_rise) |=> $stable(four_wire))
    else $error("wire mode changed outside reset");

endmodule // rsp_slave

//--- rsp_host_model.sv
// Host master model that runs frames into the serial slave port
`timescale 1ns/10ps
module rsp_host_model (
  input  wire logic clk_sys,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output logic      sck,
  output logic      ss_n,
  output logic      mosi
);
  // Clock idles low and select high: the master owns both
  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // Half of a 160 ns serial clock period
  task automatic half();
    repeat (4) @(posedge clk_sys);
  endtask

  // A count other than 16 is only used to provoke a clock-count fault
  task automatic xfer(input logic [15:0] tx, input int nclk, output logic [15:0] rx);
    rx = 16'h0000;
    ss_n <= 1'b0;
    // Data changes with the rising edge so it stands still across the falling one
    for (int i = 0; i < nclk; i++) begin
      half();
      sck  <= 1'b1;
      mosi <= tx[15 - (i % 16)];
      half();
      sck <= 1'b0;
      rx = {rx[14:0], (miso_oe_n === 1'b0) ? miso : 1'bx};
    end
    half();
    ss_n <= 1'b1;
    mosi <= ~mosi;
  endtask

  // Stray clocks with select high, for the ignore scenario only
  task automatic idle_clocks(input int n);
    repeat (n) begin
      half();
      sck <= ~sck;
    end
  endtask
endmodule // rsp_host_model

//--- rotary_encoder_spi_slave_test.sv
// Self-checking testbench of the serial slave port
`timescale 1ns/10ps
module rotary_encoder_spi_slave_test;
  logic             clk_sys = 1'b0;
  logic             reset = 1'b1;
  logic             strap = 1'b1;
  logic      [15:0] angle = 16'hA5C3;
  logic      [15:0] rx;
  wire logic        sck, ss_n, mosi, miso, oe_n, fault, four_wire, frame_done;
  wire logic [15:0] cmd_word;
  int               fail_count = 0;
  int               n_checks = 0;
  int               n_done = 0;

  rsp_slave dut_u (.clk_sys(clk_sys), .reset(reset), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .wire_mode_strap(strap), .angle_word(angle), .miso(miso), .miso_oe_n(oe_n),
    .transfer_fault_flag(fault), .four_wire(four_wire), .frame_done(frame_done),
    .cmd_word(cmd_word));
  rsp_host_model host_u (.clk_sys(clk_sys), .miso(miso), .miso_oe_n(oe_n), .sck(sck),
    .ss_n(ss_n), .mosi(mosi));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (frame_done === 1'b1) n_done++;

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] par(input logic [14:0] c);
    return {c, ^c};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_sys);
    strap <= s;
    reset <= 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check("oe_n", 16'h1, {15'h0, oe_n});
    check("fault", 16'h0, {15'h0, fault});
    check("four_wire", {15'h0, s}, {15'h0, four_wire});
  endtask
  task automatic frame(input logic [15:0] tx, input int n);
    @(posedge clk_sys);
    host_u.xfer(tx, n, rx);
    repeat (rsp_pkg::RELEASE_CYCLES) @(posedge clk_sys);
    #1 check("oe_n released", 16'h1, {15'h0, oe_n});
    repeat (7) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_exchange();
    int n0;
    n0 = n_done;
    frame(par(15'h1234), 16);
    check("cmd_word", par(15'h1234), cmd_word);
    frame(par(rsp_pkg::CMD_READ_ERR), 16);
    check("reply write", {1'b0, angle[14:0]}, rx);
    check("read accepted", 16'h0, {15'h0, fault});
    frame(16'h0000, 16);
    check("reply read", {1'b0, angle[14:0]}, rx);
    frame(16'h0000, 16);
    check("reply nop", 16'h0000, rx);
    check("frames", 16'd4, 16'(n_done - n0));
  endtask
  task automatic t_faults();
    logic [15:0] bad [3];
    bad = '{par(15'h1234) ^ 16'h0001, par(15'h7FFF), par(15'h0456)};
    for (int i = 0; i < 3; i++) begin
      do_reset(1'b1);
      frame(bad[i], (i == 2) ? 15 : 16);
      check("fault set", 16'h1, {15'h0, fault});
      frame(16'h0000, 16);
      check("reply fault bit", 16'h1, {15'h0, rx[15]});
      frame(par(rsp_pkg::CMD_CLEAR_FAULT), 16);
      check("fault cleared", 16'h0, {15'h0, fault});
    end
  endtask
  task automatic t_idle();
    int n0;
    n0 = n_done;
    host_u.idle_clocks(6);
    repeat (8) @(posedge clk_sys);
    check("idle frames", 16'h0, 16'(n_done - n0));
    check("idle fault", 16'h0, {15'h0, fault});
  endtask
  task automatic t_three_wire();
    do_reset(1'b0);
    strap <= 1'b1;
    frame(par(15'h1234) ^ 16'h0001, 16);
    frame(par(rsp_pkg::CMD_CLEAR_FAULT), 16);
    check("fault kept", 16'h1, {15'h0, fault});
    check("mode kept", 16'h0, {15'h0, four_wire});
    frame(par(rsp_pkg::CMD_SOFT_RESET), 16);
    check("mode resampled", 16'h1, {15'h0, four_wire});
    do_reset(1'b0);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
  initial begin
    do_reset(1'b1);
    t_exchange();
    t_idle();
    t_faults();
    t_three_wire();
    stop_test();
  end
endmodule // rotary_encoder_spi_slave_test
